// ===== verilog/csf_pkg.sv
// package: constants for the core status flag block
package csf_pkg;
  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_I = 2;
  localparam int FLAG_D = 3;
  localparam int FLAG_B = 4;
  localparam int FLAG_T = 5;
  localparam int FLAG_V = 6;
  localparam int FLAG_N = 7;
  localparam logic [7:0] FLAGS_RST = 8'h04;
  // register offsets
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_ACC = 4'h1;
  localparam logic [3:0] OFS_XREG = 4'h2;
  localparam logic [3:0] OFS_MEMX = 4'h3;
  localparam logic [3:0] OFS_IREQ = 4'h4;
  localparam logic [3:0] OFS_DIR = 4'h5;
  localparam logic [3:0] OFS_MODE = 4'h6;
  localparam logic [3:0] OFS_IST = 4'h7;
  localparam logic [3:0] OFS_IMSK = 4'h8;
  localparam logic [3:0] OFS_MDQ = 4'h9;
  localparam int MODE_FIX_BIT = 3;
  localparam int MODE_HS_BIT = 7;
  localparam logic [7:0] MODE_RST = 8'h08;
  // interrupt status bits
  localparam int EV_ALU = 0;
  localparam int EV_SEQ = 1;
  // timing: internal clock is oscillator / 2 with mode bit 7 set, oscillator / 8 otherwise
  localparam int PHI_DIV_HS = 2;
  localparam int PHI_DIV_LS = 8;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // operations
  typedef enum logic [3:0] {
    CSF_OP_NOP = 4'h0,
    CSF_OP_ADC = 4'h1,
    CSF_OP_SUB_BORROW = 4'h2,
    CSF_OP_SET_CARRY = 4'h3,
    CSF_OP_CLR_CARRY = 4'h4,
    CSF_OP_CLR_DEC = 4'h5,
    CSF_OP_SED = 4'h6,
    CSF_OP_MULTIPLY = 4'h7,
    CSF_OP_DIV = 4'h8,
    CSF_OP_AND = 4'h9,
    CSF_OP_ORA = 4'hA,
    CSF_OP_SET = 4'hB,
    CSF_OP_CLT = 4'hC,
    CSF_OP_BIT_SET_BR = 4'hD
  } csf_op_t;
  typedef enum logic [2:0] {
    CSF_IDLE = 3'b001,
    CSF_EXEC = 3'b010,
    CSF_DONE = 3'b100
  } csf_state_t;
endpackage

// ===== verilog/csf_core.sv
// csf_core: status flag, decimal alu, request latency and timing for the 8-bit core
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// (RULE1) on reset the interrupt-disable flag is set; other flags are undefined
// (RULE2) software initialises index-x mode and decimal flags before arithmetic
// (RULE3) an interrupt request write is seen by bit tests one instruction later
// (RULE4) with decimal flag set, add and subtract work in packed decimal
// (RULE5) software puts one instruction between decimal math and carry/decimal ops
// (RULE6) in decimal mode negative, overflow and zero flags are not valid
// (RULE7) multiply and divide ignore index-x mode and decimal flags
// (RULE8) multiply and divide leave the status register unchanged
// (RULE9) port direction register is write-only and reads give no valid data
// (RULE10) each instruction cycle takes one internal clock, oscillator over two with mode bit 7 set, over eight otherwise
// (RULE11) software keeps mode register bit 3 at one
// (RULE12) software never writes reserved addresses or bits
// (RULE13) index-x mode makes arithmetic use memory at x instead of accumulator
module csf_core import csf_pkg::*; #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // instruction issue
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [DW-1:0] op_data,
  input wire logic [3:0] op_cycles,
  output logic op_done,
  output logic bit_set_taken,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // interrupt and observation
  output logic irq,
  output logic [DW-1:0] dir_out,
  output logic phi_tick
);
  logic [DW-1:0] flags_r, acc_r, xreg_r, memx_r, ireq_r, ireq_vis_r, dir_r, mode_r;
  logic [DW-1:0] mdq_r;
  logic [1:0] ist_r, imsk_r;
  logic [3:0] div_cnt_r, cyc_cnt_r, cyc_tgt_r;
  logic phi_r, op_done_r, bit_set_r, irq_r;
  logic [DW-1:0] rdata_r;
  logic ireq_pend_r;
  logic dec_last_r;
  logic ev_seq;
  csf_state_t st_r;
  csf_op_t op_r;
  logic [DW-1:0] opnd_r;
  logic [DW-1:0] src, res;
  logic [DW:0] bin_sum;
  logic res_c, res_v;
  logic [4:0] lo_s, hi_s;
  logic lo_c, hi_c;
  logic [3:0] div_lim;

  // ------------------------------------------------
  // internal clock enable
  // ------------------------------------------------
  assign div_lim = mode_r[MODE_HS_BIT] ? 4'(PHI_DIV_HS - 1) : 4'(PHI_DIV_LS - 1);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      div_cnt_r <= 4'h0;
      phi_r <= 1'b0;
    end else if (div_cnt_r >= div_lim) begin
      div_cnt_r <= 4'h0;
      phi_r <= 1'b1; // RULE10
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
      phi_r <= 1'b0;
    end
  end
  assign phi_tick = phi_r;

  // ------------------------------------------------
  // execution sequencer
  // ------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= CSF_IDLE;
      op_r <= CSF_OP_NOP;
      opnd_r <= 8'h00;
      cyc_cnt_r <= 4'h0;
      cyc_tgt_r <= 4'h0;
      op_done_r <= 1'b0;
    end else begin
      op_done_r <= 1'b0;
      unique case (st_r)
        CSF_IDLE: begin
          if (op_valid) begin
            op_r <= csf_op_t'(op_code);
            opnd_r <= op_data;
            cyc_tgt_r <= (op_cycles == 4'h0) ? 4'h1 : op_cycles;
            cyc_cnt_r <= 4'h0;
            st_r <= CSF_EXEC;
          end
        end
        CSF_EXEC: begin
          // duration is cycle count times internal clock period
          if (phi_r) begin
            if (cyc_cnt_r + 4'h1 >= cyc_tgt_r) begin
              st_r <= CSF_DONE; // RULE10
            end
            cyc_cnt_r <= cyc_cnt_r + 4'h1;
          end
        end
        CSF_DONE: begin
          op_done_r <= 1'b1;
          st_r <= CSF_IDLE;
        end
      endcase
    end
  end
  assign op_done = op_done_r;

  // ------------------------------------------------
  // alu
  // ------------------------------------------------
  // index-x mode swaps the accumulator for memory at x
  assign src = flags_r[FLAG_T] ? memx_r : acc_r; // RULE13
  always_comb begin
    res = src;
    res_c = flags_r[FLAG_C];
    res_v = 1'b0;
    bin_sum = '0;
    lo_s = '0;
    hi_s = '0;
    lo_c = 1'b0;
    hi_c = 1'b0;
    if (op_r == CSF_OP_ADC || op_r == CSF_OP_SUB_BORROW) begin
      if (op_r == CSF_OP_ADC) begin
        bin_sum = {1'b0, src} + {1'b0, opnd_r} + {8'h00, flags_r[FLAG_C]};
      end else begin
        bin_sum = {1'b0, src} + {1'b0, ~opnd_r} + {8'h00, flags_r[FLAG_C]};
      end
      res = bin_sum[7:0];
      res_c = bin_sum[8];
      res_v = (src[7] ^ bin_sum[7]) & ~(src[7] ^ opnd_r[7] ^ (op_r == CSF_OP_SUB_BORROW));
      if (flags_r[FLAG_D]) begin
        if (op_r == CSF_OP_ADC) begin
          lo_s = {1'b0, src[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, flags_r[FLAG_C]};
          lo_c = lo_s > 5'h09;
          if (lo_c) lo_s = lo_s + 5'h06;
          hi_s = {1'b0, src[7:4]} + {1'b0, opnd_r[7:4]} + {4'h0, lo_c};
          hi_c = hi_s > 5'h09;
          if (hi_c) hi_s = hi_s + 5'h06;
        end else begin
          lo_s = {1'b0, src[3:0]} - {1'b0, opnd_r[3:0]} - {4'h0, ~flags_r[FLAG_C]};
          lo_c = lo_s[4];
          if (lo_c) lo_s = lo_s - 5'h06;
          hi_s = {1'b0, src[7:4]} - {1'b0, opnd_r[7:4]} - {4'h0, lo_c};
          hi_c = ~hi_s[4];
          if (hi_s[4]) hi_s = hi_s - 5'h06;
        end
        res = {hi_s[3:0], lo_s[3:0]}; // RULE4
        res_c = hi_c;
      end
    end else if (op_r == CSF_OP_AND) begin
      res = src & opnd_r;
    end else if (op_r == CSF_OP_ORA) begin
      res = src | opnd_r;
    end
  end

  // ------------------------------------------------
  // status flags and operands
  // ------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_r <= FLAGS_RST; // RULE1
      acc_r <= 8'h00;
      memx_r <= 8'h00;
      mdq_r <= 8'h00;
      dec_last_r <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_FLAGS) begin
      flags_r <= reg_wdata;
    end else if (reg_wr && reg_addr == OFS_ACC) begin
      acc_r <= reg_wdata;
    end else if (reg_wr && reg_addr == OFS_MEMX) begin
      memx_r <= reg_wdata;
    end else if (st_r == CSF_DONE) begin
      dec_last_r <= flags_r[FLAG_D] && (op_r == CSF_OP_ADC || op_r == CSF_OP_SUB_BORROW);
      unique case (op_r)
        CSF_OP_ADC, CSF_OP_SUB_BORROW, CSF_OP_AND, CSF_OP_ORA: begin
          if (flags_r[FLAG_T]) memx_r <= res;
          else acc_r <= res;
          flags_r[FLAG_C] <= res_c;
          // decimal results set n and z from the decimal result and v from the binary sum
          flags_r[FLAG_N] <= res[7]; // RULE6
          flags_r[FLAG_Z] <= (res == 8'h00);
          flags_r[FLAG_V] <= res_v;
        end
        CSF_OP_SET_CARRY: flags_r[FLAG_C] <= 1'b1;
        CSF_OP_CLR_CARRY: flags_r[FLAG_C] <= 1'b0;
        CSF_OP_CLR_DEC: flags_r[FLAG_D] <= 1'b0;
        CSF_OP_SED: flags_r[FLAG_D] <= 1'b1;
        CSF_OP_SET: flags_r[FLAG_T] <= 1'b1;
        CSF_OP_CLT: flags_r[FLAG_T] <= 1'b0;
        // always accumulator based, no flag written
        CSF_OP_MULTIPLY: {mdq_r, acc_r} <= 16'(acc_r * opnd_r); // RULE7 RULE8
        CSF_OP_DIV: begin
          if (opnd_r != 8'h00) begin
            acc_r <= acc_r / opnd_r; // RULE7 RULE8
            mdq_r <= acc_r % opnd_r;
          end
        end
        default: ;
      endcase
    end
  end
  // set-carry/clear-carry/clear-decimal right after decimal math
  assign ev_seq = (st_r == CSF_DONE) && dec_last_r &&
    (op_r == CSF_OP_SET_CARRY || op_r == CSF_OP_CLR_CARRY || op_r == CSF_OP_CLR_DEC);

  // ------------------------------------------------
  // other registers
  // ------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      xreg_r <= 8'h00;
      dir_r <= 8'h00;
      mode_r <= MODE_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_XREG) xreg_r <= reg_wdata;
      if (reg_addr == OFS_DIR) dir_r <= reg_wdata;
      if (reg_addr == OFS_MODE) mode_r <= reg_wdata;
    end
  end
  assign dir_out = dir_r;

  // request bits: new value reaches bit tests after one more instruction
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ireq_r <= 8'h00;
      ireq_vis_r <= 8'h00;
      ireq_pend_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_IREQ) begin
        ireq_r <= reg_wdata;
        ireq_pend_r <= 1'b1;
      end else if (st_r == CSF_DONE && ireq_pend_r) begin
        ireq_vis_r <= ireq_r; // RULE3
        ireq_pend_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bit_set_r <= 1'b0;
    end else if (st_r == CSF_DONE && op_r == CSF_OP_BIT_SET_BR) begin
      bit_set_r <= ireq_vis_r[opnd_r[2:0]]; // RULE3
    end
  end
  assign bit_set_taken = bit_set_r;

  // ------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ist_r <= 2'h0;
      imsk_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      // set wins over a same-cycle clear
      ist_r[EV_ALU] <= (st_r == CSF_DONE) | (ist_r[EV_ALU] &
        ~(reg_wr && reg_addr == OFS_IST && reg_wdata[EV_ALU]));
      ist_r[EV_SEQ] <= ev_seq | (ist_r[EV_SEQ] &
        ~(reg_wr && reg_addr == OFS_IST && reg_wdata[EV_SEQ]));
      if (reg_wr && reg_addr == OFS_IMSK) imsk_r <= reg_wdata[1:0];
      irq_r <= |(ist_r & imsk_r);
    end
  end
  assign irq = irq_r;

  // ------------------------------------------------
  // read port
  // ------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_r <= RD_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_FLAGS: rdata_r <= flags_r;
        OFS_ACC: rdata_r <= acc_r;
        OFS_XREG: rdata_r <= xreg_r;
        OFS_MEMX: rdata_r <= memx_r;
        OFS_IREQ: rdata_r <= ireq_vis_r;
        OFS_DIR: rdata_r <= RD_ZERO; // RULE9
        OFS_MODE: rdata_r <= mode_r;
        OFS_IST: rdata_r <= {6'h00, ist_r};
        OFS_IMSK: rdata_r <= {6'h00, imsk_r};
        OFS_MDQ: rdata_r <= mdq_r;
        default: rdata_r <= RD_ZERO;
      endcase
    end else begin
      rdata_r <= RD_ZERO;
    end
  end
  assign reg_rdata = rdata_r;

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  sequence s_muldiv_done;
    st_r == CSF_DONE && (op_r == CSF_OP_MULTIPLY || op_r == CSF_OP_DIV);
  endsequence
  sequence s_ireq_release;
    st_r == CSF_DONE && ireq_pend_r && !(reg_wr && reg_addr == OFS_IREQ);
  endsequence
  sequence s_dec_sub_done;
    st_r == CSF_DONE && op_r == CSF_OP_SUB_BORROW && flags_r[FLAG_D] && !flags_r[FLAG_T];
  endsequence
  chk_reset_iflag: assert property (@(posedge sys_clk) // RULE1
    !rstn |=> flags_r[FLAG_I]) else $error("interrupt disable not set after reset");
  chk_muldiv_flags: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE8
    s_muldiv_done and !reg_wr |=> $stable(flags_r)) else $error("multiply or divide changed flags");
  chk_muldiv_mode: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
    s_muldiv_done and !reg_wr |=> $stable(memx_r)) else $error("multiply or divide used x mode");
  chk_dir_read: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    reg_rd && reg_addr == OFS_DIR |=> reg_rdata == RD_ZERO) else $error("dir readable");
  chk_ireq_delay: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    reg_wr && reg_addr == OFS_IREQ |=> $stable(ireq_vis_r)) else $error("request seen early");
  chk_phi_rate: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    phi_r && mode_r[MODE_HS_BIT] && $stable(mode_r) |=> !phi_r) else $error("phi too fast");
  chk_dec_add: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    st_r == CSF_DONE && op_r == CSF_OP_ADC && flags_r[FLAG_D] && !flags_r[FLAG_T] && !reg_wr
    |=> acc_r[3:0] <= 4'h9) else $error("decimal add gave non-bcd digit");
  chk_xmode_acc: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE13
    st_r == CSF_DONE && op_r == CSF_OP_AND && flags_r[FLAG_T] && !reg_wr
    |=> $stable(acc_r)) else $error("index-x mode touched accumulator");
  chk_done_pulse: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE10
    op_done |=> !op_done) else $error("done longer than one cycle");
  // the copy must follow the written value once the next instruction has completed
  chk_ireq_release: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
    s_ireq_release |=> ireq_vis_r == $past(ireq_r)) else $error("request copy not released");
  chk_dec_sub: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
    s_dec_sub_done and !reg_wr |=> acc_r[3:0] <= 4'h9) else $error("decimal subtract non-bcd");
  chk_dir_write: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
    reg_wr && reg_addr == OFS_DIR |=> dir_out == $past(reg_wdata)) else $error("dir not written");
  chk_seq_event: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
    ev_seq |=> ist_r[EV_SEQ]) else $error("spacing event not latched");
endmodule

// ===== verification/csf_issue_model.sv
// csf_issue_model: instruction stream that feeds the core's issue port
`timescale 1ns/10ps
module csf_issue_model import csf_pkg::*; (
  // clock
  input wire logic sys_clk,
  // issue port
  output logic op_valid,
  output logic [3:0] op_code,
  output logic [7:0] op_data,
  output logic [3:0] op_cycles,
  input wire logic op_done
);
  // cleared only by a scenario that means to break the spacing on purpose
  bit guard = 1'b1;
  bit last_dec = 1'b0;

  initial begin
    op_valid = 1'b0;
    op_code = 4'h0;
    op_data = 8'h00;
    op_cycles = 4'h1;
  end

  // ----------------------------------------------------------------
  // one instruction: a single valid pulse, then a bounded wait
  // ----------------------------------------------------------------
  task automatic run(input csf_op_t op, input logic [7:0] d, input logic [3:0] n,
                     output int lat);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_data <= d;
    op_cycles <= n;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    for (lat = 0; lat < 400; lat++) begin
      @(posedge sys_clk);
      #1;
      if (op_done === 1'b1) break;
    end
  endtask

  task automatic issue(input csf_op_t op, input logic [7:0] d, input logic [3:0] n,
                       output int lat);
    if (guard && last_dec && op inside {CSF_OP_SET_CARRY, CSF_OP_CLR_CARRY, CSF_OP_CLR_DEC}) begin
      run(CSF_OP_NOP, 8'h00, 4'h1, lat);
    end
    run(op, d, n, lat);
    last_dec = op inside {CSF_OP_ADC, CSF_OP_SUB_BORROW};
  endtask
endmodule

// ===== verification/cpu_status_flag_behavior_bench.sv
// cpu_status_flag_behavior_bench: register and instruction scenarios for the core
`timescale 1ns/10ps
module cpu_status_flag_behavior_bench import csf_pkg::*;;
  logic sys_clk, rstn, reg_wr, reg_rd;
  logic [3:0] reg_addr, op_code, op_cycles;
  logic [7:0] reg_wdata, reg_rdata, op_data, dir_out, v;
  logic op_valid, op_done, bit_set_taken, irq, phi_tick;
  int n_errors = 0;
  int total_checks = 0;
  int lat, g;
  logic [7:0] tf[4] = '{8'h00, 8'h08, 8'h08, 8'h09};
  logic [7:0] ta[4] = '{8'h19, 8'h19, 8'h99, 8'h50};
  logic [7:0] td[4] = '{8'h28, 8'h28, 8'h01, 8'h01};
  logic [7:0] tr[4] = '{8'h41, 8'h47, 8'h00, 8'h49};
  logic [7:0] tc[4] = '{8'h00, 8'h00, 8'h01, 8'h01};
  csf_op_t to[4] = '{CSF_OP_ADC, CSF_OP_ADC, CSF_OP_ADC, CSF_OP_SUB_BORROW};

  csf_core #(.DW(8)) i_csf_core (.sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .op_data(op_data), .op_cycles(op_cycles), .op_done(op_done),
    .bit_set_taken(bit_set_taken), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .dir_out(dir_out),
    .phi_tick(phi_tick));
  csf_issue_model i_csf_issue_model (.sys_clk(sys_clk), .op_valid(op_valid),
    .op_code(op_code), .op_data(op_data), .op_cycles(op_cycles), .op_done(op_done));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic op(input csf_op_t o, input logic [7:0] d, input logic [3:0] n);
    i_csf_issue_model.issue(o, d, n, lat);
    if (lat >= 400) begin
      chk(8'hEE, 8'h00);
      complete_run();
    end
  endtask

  // gap in cycles between two internal clock pulses
  task automatic phi_gap();
    int k;
    // wait for a first pulse before counting so a pulse from before a mode change is never measured
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      #1;
      if (phi_tick === 1'b1) break;
    end
    for (g = 1; g < 40; g++) begin
      @(posedge sys_clk);
      #1;
      if (phi_tick === 1'b1) break;
    end
  endtask

  task automatic timing(input int div);
    phi_gap();
    chk(g[7:0], div[7:0]);
    op(CSF_OP_NOP, 8'h00, 4'h3);
    chk({7'h0, lat + 1 >= 3 * div && lat + 1 <= 4 * div + 2}, 8'h01);
  endtask

  task automatic irq_after(input logic e);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h0, irq}, {7'h0, e});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(OFS_FLAGS, v);
    chk({7'h0, v[FLAG_I]}, 8'h01);
    rd(OFS_MODE, v);
    chk(v, MODE_RST);
    rd(4'hF, v);
    chk(v, RD_ZERO);
    timing(PHI_DIV_LS);
    wr(OFS_MODE, 8'h88);
    timing(PHI_DIV_HS);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_FLAGS, tf[i]);
      wr(OFS_ACC, ta[i]);
      op(to[i], td[i], 4'h1);
      rd(OFS_ACC, v);
      chk(v, tr[i]);
      rd(OFS_FLAGS, v);
      chk(v & 8'h01, tc[i]);
    end
    // multiply and divide with both mode flags set
    wr(OFS_FLAGS, 8'h29);
    wr(OFS_ACC, 8'h12);
    op(CSF_OP_MULTIPLY, 8'h34, 4'h2);
    rd(OFS_ACC, v);
    chk(v, 8'hA8);
    rd(OFS_MDQ, v);
    chk(v, 8'h03);
    rd(OFS_FLAGS, v);
    chk(v, 8'h29);
    op(CSF_OP_DIV, 8'h05, 4'h2);
    rd(OFS_ACC, v);
    chk(v, 8'h21);
    rd(OFS_MDQ, v);
    chk(v, 8'h03);
    rd(OFS_FLAGS, v);
    chk(v, 8'h29);
    // index x mode: the sum lands in memory, accumulator untouched
    wr(OFS_FLAGS, 8'h20);
    wr(OFS_ACC, 8'h55);
    wr(OFS_MEMX, 8'h10);
    op(CSF_OP_ADC, 8'h05, 4'h1);
    rd(OFS_MEMX, v);
    chk(v, 8'h15);
    rd(OFS_ACC, v);
    chk(v, 8'h55);
    op(CSF_OP_AND, 8'h0F, 4'h1);
    op(CSF_OP_ORA, 8'hA0, 4'h1);
    rd(OFS_MEMX, v);
    chk(v, 8'hA5);
    rd(OFS_ACC, v);
    chk(v, 8'h55);
    // single-flag instructions: set three, then clear them again
    wr(OFS_FLAGS, 8'h00);
    op(CSF_OP_SET, 8'h00, 4'h1);
    op(CSF_OP_SED, 8'h00, 4'h1);
    op(CSF_OP_SET_CARRY, 8'h00, 4'h1);
    rd(OFS_FLAGS, v);
    chk(v, 8'h29);
    op(CSF_OP_CLT, 8'h00, 4'h1);
    op(CSF_OP_CLR_DEC, 8'h00, 4'h1);
    op(CSF_OP_CLR_CARRY, 8'h00, 4'h1);
    rd(OFS_FLAGS, v);
    chk(v, 8'h00);
    wr(OFS_DIR, 8'hA5);
    #1 chk(dir_out, 8'hA5);
    rd(OFS_DIR, v);
    chk(v, RD_ZERO);
    wr(OFS_IREQ, 8'h01);
    op(CSF_OP_BIT_SET_BR, 8'h00, 4'h1);
    chk({7'h0, bit_set_taken}, 8'h00);
    op(CSF_OP_BIT_SET_BR, 8'h00, 4'h1);
    chk({7'h0, bit_set_taken}, 8'h01);
    // completion event: masked, then unmasked, then cleared
    wr(OFS_IMSK, 8'h00);
    wr(OFS_IST, 8'h03);
    op(CSF_OP_NOP, 8'h00, 4'h1);
    irq_after(1'b0);
    rd(OFS_IST, v);
    chk(v & 8'h01, 8'h01);
    wr(OFS_IMSK, 8'h01);
    irq_after(1'b1);
    wr(OFS_IST, 8'h01);
    irq_after(1'b0);
    // carry op right after decimal math: spaced, then back to back
    wr(OFS_IMSK, 8'h02);
    wr(OFS_FLAGS, 8'h08);
    op(CSF_OP_ADC, 8'h01, 4'h1);
    op(CSF_OP_CLR_CARRY, 8'h00, 4'h1);
    irq_after(1'b0);
    i_csf_issue_model.guard = 1'b0;
    op(CSF_OP_ADC, 8'h01, 4'h1);
    op(CSF_OP_CLR_CARRY, 8'h00, 4'h1);
    i_csf_issue_model.guard = 1'b1;
    irq_after(1'b1);
    rd(OFS_IST, v);
    chk(v & 8'h02, 8'h02);
    complete_run();
  end
endmodule
